// File: hw/fsp_core_end.sv
`timescale 1ns/1ps
`include "fsp_regs.svh"
// Core-side end: turns plain register-port orders into the timed sequences.
module fsp_core_end
  import fsp_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [1:0] addr, // 0 ctrl, 1 pointer, 2 data, 3 lpm.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [15:0] rdata, // Read data, one cycle later.
  fsp_if.core lnk // Link to device.
);
  logic [15:0] zp;
  logic [15:0] dat;
  logic [7:0] cmd;
  logic [1:0] seq;
  logic [7:0] lpm_val;
  logic lpm_req;
  logic lpm_take;
  wire wr_ctrl = wr && addr == 2'h0;
  wire wr_lpm = wr && addr == 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // A control write with the enable bit set is followed by SPM next cycle, well inside the window.
  assign lnk.ctrl_wr = seq == 2'h1;
  assign lnk.ctrl_wdata = cmd;
  assign lnk.spm = seq == 2'h2 && cmd[`FSP_BIT_EN] && !lpm_req;
  assign lnk.lpm = seq == 2'h2 && lpm_req;
  assign lnk.zptr = zp;
  assign lnk.data_low_reg = dat[7:0];
  assign lnk.data_high_reg = dat[15:8];

  // A read order writes the set-and-enable pair and follows it with a load;
  // a separate flag marks it, so every command bit reaches the device as is.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      zp <= 16'h0000;
      dat <= 16'h0000;
      cmd <= 8'h00;
      seq <= 2'h0;
      lpm_val <= 8'h00;
      lpm_req <= 1'b0;
      lpm_take <= 1'b0;
    end else begin
      if (wr && addr == 2'h1) zp <= wdata;
      if (wr && addr == 2'h2) dat <= wdata;
      if (wr_ctrl || wr_lpm) begin
        cmd <= wr_lpm ? {3'h0, `FSP_CMD_LOCK} : wdata[7:0];
        lpm_req <= wr_lpm;
        seq <= 2'h1;
      end else if (seq != 2'h0) begin
        seq <= seq == 2'h2 ? 2'h0 : 2'h2;
      end
      // The device registers its answer, so take it one edge after the load.
      lpm_take <= lnk.lpm_special;
      if (lpm_take) lpm_val <= lnk.lpm_data;
    end
  end

  // Register read port: rdata takes the addressed register one cycle after the read strobe.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rdata <= 16'h0000;
    else if (rd) begin
      case (addr)
        2'h0: rdata <= {8'h00, lnk.ctrl_rdata};
        2'h1: rdata <= zp;
        2'h2: rdata <= dat;
        default: rdata <= {8'h00, lpm_val};
      endcase
    end
  end
endmodule

// File: hw/fsp_dev_end.sv
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_dev_end
  import fsp_pkg::*;
#(
  parameter int WRITE_CYCLES = `FSP_WRITE_US * `FSP_CLK_MHZ, // Write time.
  parameter int PAGE_WORDS = 32, // Words per page.
  parameter int RWW_PAGES = 96 // Pages in rewritable section.
) (
  input wire logic core_clk, // Clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic eeprom_write_busy, // EEPROM write in progress.
  input wire logic [7:0] fuse_low_byte, // Fuse state, 1 unprogrammed.
  input wire logic [7:0] fuse_high_byte, // Fuse state, 1 unprogrammed.
  input wire logic [7:0] extended_fuse_byte, // Low four bits used.
  input wire logic [1:0] memory_lock, // Memory lock bits 2..1.
  input wire logic [4:0] buf_raddr, // Buffer word read index.
  output logic [15:0] buf_rdata, // Buffer word read data.
  output logic [5:0] page_addr, // Low six bits of the page being erased or written.
  output logic [1:0] flash_op, // 1 erase, 2 write, 3 lock; 0 idle.
  output logic [3:0] boot_lock, // Boot locks, 0 programmed.
  fsp_if.dev lnk // Link to core.
);
  localparam int WW = $clog2(PAGE_WORDS);
  localparam int CW = $clog2(WRITE_CYCLES + 1);
  if (PAGE_WORDS != 32 || WRITE_CYCLES < 1 || RWW_PAGES < 1 ||
      RWW_PAGES > 127) begin : g_bad_params
    $error("fsp_dev_end: unsupported parameters");
  end

  typedef enum logic [2:0] {
    FSP_IDLE = 3'b001,
    FSP_ARMED = 3'b010,
    FSP_BUSY = 3'b100
  } fsp_state_t;

  fsp_state_t state;
  fsp_op_t op;
  logic [7:0] cmd;
  logic [2:0] win;
  logic [CW-1:0] cnt;
  logic [6:0] page;
  logic ie;
  logic busy_flag;
  logic [15:0] pbuf [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] loaded;
  logic [7:0] rd_val;

  //////////////////////////////////////////////////////////////////////////
  // Command decode; the top three bits are masked off before matching.
  wire [4:0] low5 = lnk.ctrl_wdata[4:0];
  wire valid_cmd = low5 == `FSP_CMD_LOAD || low5 == `FSP_CMD_ERASE ||
    low5 == `FSP_CMD_WRITE || low5 == `FSP_CMD_LOCK ||
    low5 == `FSP_CMD_REEN;
  // Commands are refused while EEPROM busy or a flash operation runs.
  wire take_cmd = lnk.ctrl_wr && valid_cmd && !eeprom_write_busy &&
    state != FSP_BUSY;
  wire spm_go = state == FSP_ARMED && lnk.spm && !eeprom_write_busy;
  // The load counts only in the first three armed cycles of the window.
  wire lpm_rd = state == FSP_ARMED && lnk.lpm && cmd[4:0] == `FSP_CMD_LOCK &&
    win > (`FSP_SPM_WIN - `FSP_LPM_WIN) && !eeprom_write_busy;
  wire [WW-1:0] word = lnk.zptr[WW:1];
  wire [6:0] zpage = lnk.zptr[12:6];
  wire long_op = op == FSP_OP_ERASE || op == FSP_OP_WRITE;
  wire in_rww = page < 7'(RWW_PAGES);
  wire [7:0] lock_byte = {2'b11, boot_lock, memory_lock};

  // Read-back mux; any other pointer reads all ones.
  assign rd_val = lnk.zptr == `FSP_PTR_LOCK ? lock_byte :
    lnk.zptr == `FSP_PTR_FUSE_LO ? fuse_low_byte :
    lnk.zptr == `FSP_PTR_FUSE_HI ? fuse_high_byte :
    lnk.zptr == `FSP_PTR_FUSE_EXT ?
    (extended_fuse_byte | ~`FSP_EXT_MASK) : `FSP_FUSE_DEF;

  // Only page erase and page write block the rewritable section.
  assign lnk.rww_block = busy_flag;
  assign lnk.cpu_halt = state == FSP_BUSY && long_op && !in_rww;
  assign lnk.irq = ie && state != FSP_BUSY && state != FSP_ARMED;
  assign lnk.lpm_special = lpm_rd;
  assign lnk.ctrl_rdata = {ie, busy_flag, 1'b0,
    state == FSP_ARMED ? cmd[4:1] : (state == FSP_BUSY ?
    {1'b0, op == FSP_OP_LOCK, op == FSP_OP_WRITE, op == FSP_OP_ERASE} : 4'h0),
    state != FSP_IDLE};
  assign page_addr = page[5:0];
  assign flash_op = state != FSP_BUSY ? 2'h0 : op == FSP_OP_ERASE ? 2'h1 :
    op == FSP_OP_WRITE ? 2'h2 : 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer. The reset clears arming and the interrupt enable; a running write keeps going
  // because its counter is held here on a separate reset-free path below.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win <= 3'h0;
      cmd <= 8'h00;
      ie <= 1'b0;
    end else begin
      if (lnk.ctrl_wr) ie <= lnk.ctrl_wdata[`FSP_BIT_IE];
      if (take_cmd) begin
        cmd <= lnk.ctrl_wdata;
        win <= `FSP_SPM_WIN;
      end else if (spm_go || lpm_rd || win == 3'h1) begin
        win <= 3'h0;
      end else if (win != 3'h0) begin
        win <= win - 3'h1;
      end
    end
  end

  // Flash operation timer runs with no reset so a reset cannot cut it short.
  always_ff @(posedge core_clk) begin
    if (spm_go && cmd[4:0] != `FSP_CMD_LOAD && cmd[4:0] != `FSP_CMD_REEN) begin
      cnt <= CW'(WRITE_CYCLES);
      op <= cmd[`FSP_BIT_LOCK] ? FSP_OP_LOCK :
        cmd[`FSP_BIT_WRITE] ? FSP_OP_WRITE : FSP_OP_ERASE;
      page <= zpage;
    end else if (cnt != '0) begin
      cnt <= cnt - CW'(1);
    end else begin
      op <= FSP_OP_LOAD;
    end
  end

  // State follows the window and the timer; both drive it every cycle.
  always_comb begin
    if (cnt != '0 && op != FSP_OP_LOAD) state = FSP_BUSY;
    else if (win != 3'h0) state = FSP_ARMED;
    else state = FSP_IDLE;
  end

  // Busy flag: set by any erase/write start and kept set while one runs, so
  // a reset in mid-write cannot leave the section looking readable. Only a
  // re-enable or a load clears it outside reset; reset clears it too.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_flag <= 1'b0;
    end else if ((spm_go && (cmd[4:0] == `FSP_CMD_ERASE ||
        cmd[4:0] == `FSP_CMD_WRITE)) || (state == FSP_BUSY && long_op)) begin
      busy_flag <= 1'b1;
    end else if (spm_go && (cmd[4:0] == `FSP_CMD_REEN ||
        cmd[4:0] == `FSP_CMD_LOAD)) begin
      busy_flag <= 1'b0;
    end
  end

  // Lock bits: each zero in data bits 5..2 programs a lock, never unprograms.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) boot_lock <= `FSP_LOCK_DEF;
    else if (spm_go && cmd[4:0] == `FSP_CMD_LOCK)
      boot_lock <= boot_lock & lnk.data_low_reg[5:2];
  end

  // Read-back data register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) lnk.lpm_data <= 8'h00;
    else if (lpm_rd) lnk.lpm_data <= rd_val;
  end

  //////////////////////////////////////////////////////////////////////////
  // Temporary page buffer. A clear wins over a load in the same cycle.
  wire write_done = state == FSP_BUSY && op == FSP_OP_WRITE && cnt == CW'(1);
  wire buf_clear = write_done || (spm_go && cmd[4:0] == `FSP_CMD_REEN) ||
    (eeprom_write_busy && loaded != '0);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded <= '0;
      for (int i = 0; i < PAGE_WORDS; i++) pbuf[i] <= 16'hFFFF;
    end else if (buf_clear) begin
      loaded <= '0;
      for (int i = 0; i < PAGE_WORDS; i++) pbuf[i] <= 16'hFFFF;
    end else if (spm_go && cmd[4:0] == `FSP_CMD_LOAD) begin
      loaded[word] <= 1'b1;
      pbuf[word] <= {lnk.data_high_reg, lnk.data_low_reg};
    end
  end

  // Buffer inspection port for the flash array.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) buf_rdata <= 16'hFFFF;
    else buf_rdata <= pbuf[buf_raddr];
  end
endmodule

// File: hw/fsp_if.sv
`timescale 1ns/1ps
// Core-side link: control register access plus program-memory instructions.
interface fsp_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic spm;
  logic lpm;
  logic [15:0] zptr;
  logic [7:0] data_low_reg;
  logic [7:0] data_high_reg;
  logic [7:0] lpm_data;
  logic lpm_special;
  logic cpu_halt;
  logic rww_block;
  logic irq;
  modport dev (input ctrl_wr, ctrl_wdata, spm, lpm, zptr, data_low_reg,
    data_high_reg, output ctrl_rdata, lpm_data, lpm_special, cpu_halt,
    rww_block, irq);
  modport core (output ctrl_wr, ctrl_wdata, spm, lpm, zptr, data_low_reg,
    data_high_reg, input ctrl_rdata, lpm_data, lpm_special, cpu_halt,
    rww_block, irq);
endinterface

// File: hw/fsp_pkg.sv
package fsp_pkg;
  // Operation started by a store-program instruction.
  typedef enum logic [2:0] {
    FSP_OP_LOAD = 3'h0,
    FSP_OP_ERASE = 3'h1,
    FSP_OP_WRITE = 3'h2,
    FSP_OP_LOCK = 3'h3,
    FSP_OP_REEN = 3'h4
  } fsp_op_t;
endpackage

// File: hw/fsp_regs.svh
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
// Control register bit positions.
`define FSP_BIT_EN 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCK 3
`define FSP_BIT_REEN 4
`define FSP_BIT_BUSY 6
`define FSP_BIT_IE 7
// Valid low-five command patterns.
`define FSP_CMD_LOAD 5'h01
`define FSP_CMD_ERASE 5'h03
`define FSP_CMD_WRITE 5'h05
`define FSP_CMD_LOCK 5'h09
`define FSP_CMD_REEN 5'h11
// Arming windows in cycles.
`define FSP_SPM_WIN 3'h4
`define FSP_LPM_WIN 3'h3
// Read-back pointer values.
`define FSP_PTR_FUSE_LO 16'h0000
`define FSP_PTR_LOCK 16'h0001
`define FSP_PTR_FUSE_EXT 16'h0002
`define FSP_PTR_FUSE_HI 16'h0003
`define FSP_LOCK_DEF 4'hF
`define FSP_FUSE_DEF 8'hFF
`define FSP_EXT_MASK 8'h0F
// Flash write time, microseconds, and cycles at 20 MHz.
`define FSP_WRITE_US 3700
`define FSP_CLK_MHZ 20
`endif

// File: test/fsp_link_assertions.sv
`timescale 1ns/1ps
// Watches the link between the core end and the device end.
module fsp_link_assertions (
  input wire logic core_clk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic ctrl_wr, // Control write pulse.
  input wire logic [7:0] ctrl_rdata, // Control status.
  input wire logic spm, // Store pulse.
  input wire logic lpm, // Load pulse.
  input wire logic lpm_special, // Fuse or lock read.
  input wire logic cpu_halt, // Core halted.
  input wire logic rww_block, // Section blocked.
  input wire logic irq // Interrupt request.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  // A store needs a control write no more than four cycles before it.
  a_spm_armed: assert property (
    spm |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3)
    || $past(ctrl_wr, 4)) else $error("Store without a recent command.");
  a_write_blocks: assert property (
    $rose(ctrl_rdata[2]) |-> ##[0:4] rww_block)
    else $error("Page write did not block the section.");
  a_lock_open: assert property (
    $rose(ctrl_rdata[3]) |-> (!rww_block && !cpu_halt)[*8])
    else $error("Flash unavailable during lock work.");
  a_busy_set: assert property (
    rww_block[*2] |-> ctrl_rdata[6])
    else $error("Busy flag low while blocked.");
  // Busy may only drop through a store, which follows a re-enable or a load.
  a_busy_held: assert property (
    ctrl_rdata[6] && !spm |=> ctrl_rdata[6])
    else $error("Busy flag dropped without re-enable.");
  a_en_clears: assert property (
    $rose(ctrl_rdata[0]) && ctrl_rdata[3:1] == 3'h0 |-> ##[1:5] !ctrl_rdata[0])
    else $error("Enable did not clear itself.");
  a_special_arm: assert property (
    lpm_special |-> lpm && ($past(ctrl_wr) || $past(ctrl_wr, 2)
    || $past(ctrl_wr, 3))) else $error("Special load out of window.");
  a_lock_rd_clr: assert property (
    lpm_special |-> ##[1:2] !ctrl_rdata[3]) else $error("Lock-set stuck.");
  a_irq_on: assert property (
    (ctrl_rdata[7] && !ctrl_rdata[0])[*2] |-> irq)
    else $error("Interrupt missing while enable clear.");
  a_irq_off: assert property (
    (!ctrl_rdata[7])[*2] |-> !irq) else $error("Interrupt while disabled.");
  c_block: cover property ($rose(rww_block));
  c_halt: cover property ($rose(cpu_halt));
  c_special: cover property (lpm_special);
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
// Both ends joined; the bench drives the software port and the far pins.
module tb
  import fsp_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic eeprom_write_busy = 1'b0;
  logic [7:0] fuse_low_byte, fuse_high_byte, extended_fuse_byte;
  logic [1:0] memory_lock;
  logic [4:0] buf_raddr = 5'h00;
  logic [15:0] rdata, buf_rdata, st;
  logic [5:0] page_addr;
  logic [1:0] flash_op;
  logic [3:0] boot_lock, bl;
  logic rd_d = 1'b0, bq = 1'b0, bq_d = 1'b0, sq = 1'b0, sq_d = 1'b0;
  logic [15:0] qe[$], qm[$], d[3];
  logic [31:0] r;
  int err_total = 0, samples_checked = 0, seed = 66, cyc = 0;
  fsp_if lnk_if();
  fsp_core_end i_fsp_core_end (.core_clk, .reset_n, .addr, .wdata, .wr,
    .rd, .rdata, .lnk(lnk_if.core));
  // Short write time keeps each flash operation at twenty cycles.
  fsp_dev_end #(.WRITE_CYCLES(20)) i_fsp_dev_end (.core_clk, .reset_n,
    .eeprom_write_busy, .fuse_low_byte, .fuse_high_byte, .extended_fuse_byte,
    .memory_lock, .buf_raddr, .buf_rdata, .page_addr, .flash_op, .boot_lock,
    .lnk(lnk_if.dev));
  fsp_link_assertions i_fsp_link_assertions (.core_clk, .reset_n,
    .ctrl_wr(lnk_if.ctrl_wr), .ctrl_rdata(lnk_if.ctrl_rdata),
    .spm(lnk_if.spm), .lpm(lnk_if.lpm), .lpm_special(lnk_if.lpm_special),
    .cpu_halt(lnk_if.cpu_halt), .rww_block(lnk_if.rww_block),
    .irq(lnk_if.irq));
  // Status probe: op, halt, block, boot locks, page.
  assign st = {2'h0, flash_op, lnk_if.cpu_halt, lnk_if.rww_block, boot_lock,
    page_addr};
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task final_report();
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hung wait must still end in the verdict.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end
  task chk(input logic [15:0] got);
    logic [15:0] e, m;
    e = qe.pop_front();
    m = qm.pop_front();
    samples_checked++;
    if ((got & m) !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, got & m);
    end
  endtask
  task cmp_rd(); chk(rdata); endtask
  task cmp_buf(); chk(buf_rdata); endtask
  task cmp_st(); chk(st); endtask
  // Results land two edges after their request; pop the oldest note.
  always @(posedge core_clk) begin
    rd_d <= rd;
    bq_d <= bq;
    sq_d <= sq;
    if (rd_d) cmp_rd();
    if (bq_d) cmp_buf();
    if (sq_d) cmp_st();
  end
  ////////////////////////////////////////////////////////////////////////
  task step(input int n); repeat (n) @(posedge core_clk); endtask
  task note(input logic [15:0] e, input logic [15:0] m);
    qe.push_back(e & m);
    qm.push_back(m);
  endtask
  task put(input logic [1:0] a, input logic [15:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task get(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m);
    note(e, m);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    step(2);
  endtask
  task bufchk(input logic [4:0] i, input logic [15:0] e);
    note(e, 16'hFFFF);
    @(posedge core_clk);
    buf_raddr <= i;
    bq <= 1'b1;
    @(posedge core_clk);
    bq <= 1'b0;
    step(2);
  endtask
  task stchk(input logic [15:0] e, input logic [15:0] m);
    note(e, m);
    @(posedge core_clk);
    sq <= 1'b1;
    @(posedge core_clk);
    sq <= 1'b0;
    step(2);
  endtask
  task cmd(input logic [15:0] p, input logic [15:0] v, input logic [15:0] c);
    put(2'h1, p);
    put(2'h2, v);
    put(2'h0, c);
    step(4);
  endtask
  task wait_done();
    for (int n = 0; n < 100 && flash_op !== 2'h0; n++) @(posedge core_clk);
  endtask
  function logic [15:0] rb(input int p, input logic [3:0] b);
    case (p)
      0: rb = {8'h00, fuse_low_byte};
      1: rb = {10'h000, b, memory_lock};
      2: rb = {8'h00, 4'hF, extended_fuse_byte[3:0]};
      default: rb = {8'h00, fuse_high_byte};
    endcase
  endfunction
  task fetch(input int p, input logic [3:0] b);
    put(2'h1, 16'(p));
    put(2'h3, 16'h0089);
    step(2);
    get(2'h3, rb(p, b), p == 1 ? 16'h003F : 16'h00FF);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    r = $random(seed);
    {bl, memory_lock, extended_fuse_byte, fuse_high_byte,
      fuse_low_byte} = r[29:0];
    foreach (d[i]) d[i] = 16'($random(seed));
    step(3);
    reset_n <= 1'b1;
    for (int p = 0; p < 4; p++) fetch(p, 4'hF);
    get(2'h0, 16'h0000, 16'h0009);
    // Load three words once each; an untouched word stays erased.
    for (int i = 0; i < 3; i++) cmd(16'(i * 20), d[i], 16'h0001);
    for (int i = 0; i < 3; i++) bufchk(5'(i * 10), d[i]);
    bufchk(5'h1F, 16'hFFFF);
    cmd(16'h01C0, 16'h0000, 16'h0007);
    stchk(16'h0000, 16'h3000);
    cmd(16'h01C0, 16'h0000, 16'h0085);
    stchk(16'h2407, 16'h3C3F);
    wait_done();
    get(2'h0, 16'h0040, 16'h0040);
    bufchk(5'h00, 16'hFFFF);
    cmd(16'h0000, 16'h0000, 16'h0011);
    get(2'h0, 16'h0000, 16'h0040);
    // A protected-section write halts the core.
    cmd(16'h1900, 16'h0000, 16'h0005);
    stchk(16'h2C00, 16'h3C00);
    wait_done();
    cmd(16'h0000, 16'h0000, 16'h0011);
    // EEPROM activity drops loaded data and refuses commands.
    cmd(16'h0004, d[0], 16'h0001);
    eeprom_write_busy <= 1'b1;
    cmd(16'h01C0, 16'h0000, 16'h0005);
    stchk(16'h0000, 16'h3000);
    eeprom_write_busy <= 1'b0;
    bufchk(5'h02, 16'hFFFF);
    // Reset in mid-write: the write runs on, the buffer is erased.
    cmd(16'h0004, d[1], 16'h0001);
    cmd(16'h01C0, 16'h0000, 16'h0005);
    reset_n <= 1'b0;
    step(2);
    reset_n <= 1'b1;
    stchk(16'h2000, 16'h3000);
    bufchk(5'h02, 16'hFFFF);
    wait_done();
    cmd(16'h0000, 16'h0000, 16'h0011);
    cmd(16'h0001, {8'h00, 2'b11, bl, 2'b11}, 16'h0009);
    stchk(16'h3000, 16'h3C00);
    wait_done();
    stchk({6'h00, bl, 6'h00}, 16'h03C0);
    fetch(1, bl);
    final_report();
  end
endmodule
